// File: bbr_pkg.sv
package bbr_pkg;

	// Address map of bands and aliases
	localparam logic [31:0] SRAM_BAND_BASE  = 32'h2000_0000;
	localparam logic [31:0] SRAM_BAND_END   = 32'h2000_FFFF;
	localparam logic [31:0] SRAM_ALIAS_BASE = 32'h2200_0000;
	localparam logic [31:0] SRAM_ALIAS_END  = 32'h221F_FFFF;
	localparam logic [31:0] PERI_BAND_BASE  = 32'h4000_0000;
	localparam logic [31:0] PERI_BAND_END   = 32'h400F_FFFF;
	localparam logic [31:0] PERI_ALIAS_BASE = 32'h4200_0000;
	localparam logic [31:0] PERI_ALIAS_END  = 32'h43FF_FFFF;

	// Alias address field layout
	localparam int BIT_NUM_LSB = 2;
	localparam int BIT_NUM_W   = 3;
	localparam int BYTE_OFS_LSB = 5;
	localparam int BYTE_OFS_W  = 20;
	localparam int LANE_W      = 2;

	// Access sizes
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;

	// Address alignment masks per size
	localparam logic [31:0] ALIGN_HALF = 32'hFFFF_FFFE;
	localparam logic [31:0] ALIGN_WORD = 32'hFFFF_FFFC;

	// Alias read answers and reset values
	localparam logic [31:0] ALIAS_RD_CLR = 32'h0000_0000;
	localparam logic [31:0] ALIAS_RD_SET = 32'h0000_0001;
	localparam logic [31:0] BIT0_ONE     = 32'h0000_0001;
	localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

	// Sequencer states, Gray along idle-read-writeback
	typedef enum logic [1:0] {
		st_idle  = 2'h0,
		st_read  = 2'h1,
		st_wback = 2'h3,
		st_pass  = 2'h2
	} bbr_state_t;

endpackage

// File: bbr_dec_if.sv
`timescale 1ns/1ps
interface bbr_dec_if;
	logic [31:0] addr;
	logic [1:0]  size;
	logic        instr;
	logic        is_alias;
	logic        is_fault;
	logic [31:0] tgt_addr;
	logic [4:0]  bit_idx;

	// Decoder side computes the remap
	modport decoder (
		input  addr, size, instr,
		output is_alias, is_fault, tgt_addr, bit_idx
	);

	// Sequencer side supplies the request
	modport user (
		output addr, size, instr,
		input  is_alias, is_fault, tgt_addr, bit_idx
	);
endinterface

// File: bbr_decode.sv
`timescale 1ns/1ps
module bbr_decode (
	// Request in, remap out
	bbr_dec_if.decoder dec
);
	localparam int BYTE_OFS_W = bbr_pkg::BYTE_OFS_W;
	localparam int BIT_NUM_W  = bbr_pkg::BIT_NUM_W;

	wire                  in_sram_alias;
	wire                  in_peri_alias;
	wire [BYTE_OFS_W-1:0] byte_ofs;
	wire [BIT_NUM_W-1:0]  bit_num;
	wire [31:0]           band_base;
	wire [31:0]           byte_addr;
	wire [31:0]           align_mask;

	// Alias window match
	assign in_sram_alias = (dec.addr >= bbr_pkg::SRAM_ALIAS_BASE) && (dec.addr <= bbr_pkg::SRAM_ALIAS_END);
	assign in_peri_alias = (dec.addr >= bbr_pkg::PERI_ALIAS_BASE) && (dec.addr <= bbr_pkg::PERI_ALIAS_END);

	// Only data accesses remap; fetches from peripheral alias fault
	assign dec.is_alias = (in_sram_alias || in_peri_alias) && !dec.instr;
	assign dec.is_fault = in_peri_alias && dec.instr;

	// Split alias address into byte offset and bit number, low two bits dropped
	assign byte_ofs = dec.addr[bbr_pkg::BYTE_OFS_LSB +: BYTE_OFS_W];
	assign bit_num  = dec.addr[bbr_pkg::BIT_NUM_LSB +: BIT_NUM_W];

	// Band byte address of the targeted bit
	assign band_base = in_peri_alias ? bbr_pkg::PERI_BAND_BASE : bbr_pkg::SRAM_BAND_BASE;
	assign byte_addr = band_base + {12'h000, byte_ofs};

	// Same size as the alias access, naturally aligned
	assign align_mask = (dec.size == bbr_pkg::SIZE_WORD) ? bbr_pkg::ALIGN_WORD :
	                    (dec.size == bbr_pkg::SIZE_HALF) ? bbr_pkg::ALIGN_HALF : 32'hFFFF_FFFF;
	assign dec.tgt_addr = byte_addr & align_mask;

	// Little-endian lane: byte address low bits pick the byte lane
	assign dec.bit_idx = {byte_addr[bbr_pkg::LANE_W-1:0], bit_num};
endmodule

// File: bbr_top.sv
`timescale 1ns/1ps
module bbr_top (
	// Clock, reset, enable
	input  wire logic        core_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        ce_i,
	// Upstream request from the core
	input  wire logic        up_req_i,
	input  wire logic [31:0] up_addr_i,
	input  wire logic        up_write_i,
	input  wire logic [1:0]  up_size_i,
	input  wire logic [31:0] up_wdata_i,
	input  wire logic        up_instr_i,
	// Upstream answer
	output logic             up_ready_o,
	output logic             up_done_o,
	output logic             up_fault_o,
	output logic [31:0]      up_rdata_o,
	// Downstream request to memory fabric
	output logic             dn_req_o,
	output logic [31:0]      dn_addr_o,
	output logic             dn_write_o,
	output logic [1:0]       dn_size_o,
	output logic [31:0]      dn_wdata_o,
	// Downstream answer
	input  wire logic        dn_done_i,
	input  wire logic [31:0] dn_rdata_i
);
	// Reset synchroniser
	logic rst_meta;
	logic rst_b;

	// Sequencer state and latched alias context
	bbr_pkg::bbr_state_t state;
	bbr_pkg::bbr_state_t next_state;
	logic        alias_write;
	logic        alias_wbit;
	logic [4:0]  alias_bit;
	logic        next_alias_write;
	logic        next_alias_wbit;
	logic [4:0]  next_alias_bit;

	// Next values of the outputs
	logic        next_up_ready;
	logic        next_up_done;
	logic        next_up_fault;
	logic [31:0] next_up_rdata;
	logic        next_dn_req;
	logic [31:0] next_dn_addr;
	logic        next_dn_write;
	logic [1:0]  next_dn_size;
	logic [31:0] next_dn_wdata;

	// Decode helpers
	wire         accept;
	wire [31:0]  bit_mask;
	wire         read_bit;
	wire [31:0]  merged_word;
	wire [31:0]  alias_answer;
	wire [31:0]  wbit_word;

	bbr_dec_if dec ();

	// Present the raw request to the decoder
	assign dec.addr  = up_addr_i;
	assign dec.size  = up_size_i;
	assign dec.instr = up_instr_i;

	bbr_decode u_decode (
		.dec (dec)
	);

	// Request is taken only while idle and enabled
	assign accept = ce_i && up_ready_o && up_req_i;

	// Bit pick and merge on the fetched underlying data
	assign bit_mask     = bbr_pkg::BIT0_ONE << alias_bit;
	assign read_bit     = dn_rdata_i[alias_bit];
	assign alias_answer = read_bit ? bbr_pkg::ALIAS_RD_SET : bbr_pkg::ALIAS_RD_CLR;
	assign wbit_word    = alias_wbit ? bit_mask : bbr_pkg::WORD_ZERO;
	assign merged_word  = (dn_rdata_i & ~bit_mask) | wbit_word;

	// Release reset through two flops
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_meta <= 1'b0;
			rst_b    <= 1'b0;
		end else if (ce_i) begin
			rst_meta <= 1'b1;
			rst_b    <= rst_meta;
		end
	end

	// Sequencer next-state and output planning
	always_comb begin
		next_state       = state;
		next_alias_write = alias_write;
		next_alias_wbit  = alias_wbit;
		next_alias_bit   = alias_bit;
		next_up_ready    = (state == bbr_pkg::st_idle);
		next_up_done     = 1'b0;
		next_up_fault    = 1'b0;
		next_up_rdata    = up_rdata_o;
		next_dn_req      = 1'b0;
		next_dn_addr     = dn_addr_o;
		next_dn_write    = dn_write_o;
		next_dn_size     = dn_size_o;
		next_dn_wdata    = dn_wdata_o;
		case (state)
			bbr_pkg::st_idle: begin
				if (accept) begin
					if (dec.is_fault) begin
						// Fetch from peripheral alias is refused at once
						next_up_done  = 1'b1;
						next_up_fault = 1'b1;
						next_up_rdata = bbr_pkg::WORD_ZERO;
					end else if (dec.is_alias) begin
						// Alias access starts with a read of the underlying data
						next_state       = bbr_pkg::st_read;
						next_alias_write = up_write_i;
						next_alias_wbit  = up_wdata_i[0];
						next_alias_bit   = dec.bit_idx;
						next_up_ready    = 1'b0;
						next_dn_req      = 1'b1;
						next_dn_addr     = dec.tgt_addr;
						next_dn_write    = 1'b0;
						next_dn_size     = up_size_i;
						next_dn_wdata    = bbr_pkg::WORD_ZERO;
					end else begin
						// Direct band, other space and SRAM alias fetches pass as is
						next_state    = bbr_pkg::st_pass;
						next_up_ready = 1'b0;
						next_dn_req   = 1'b1;
						next_dn_addr  = up_addr_i;
						next_dn_write = up_write_i;
						next_dn_size  = up_size_i;
						next_dn_wdata = up_wdata_i;
					end
				end
			end
			bbr_pkg::st_read: begin
				if (dn_done_i) begin
					if (alias_write) begin
						// Write back the word with only the target bit changed
						next_state    = bbr_pkg::st_wback;
						next_dn_req   = 1'b1;
						next_dn_write = 1'b1;
						next_dn_wdata = merged_word;
					end else begin
						// Alias read answers zero or one
						next_state    = bbr_pkg::st_idle;
						next_up_ready = 1'b1;
						next_up_done  = 1'b1;
						next_up_rdata = alias_answer;
					end
				end
			end
			bbr_pkg::st_wback: begin
				if (dn_done_i) begin
					next_state    = bbr_pkg::st_idle;
					next_up_ready = 1'b1;
					next_up_done  = 1'b1;
					next_up_rdata = bbr_pkg::WORD_ZERO;
					next_dn_write = 1'b0;
				end
			end
			bbr_pkg::st_pass: begin
				if (dn_done_i) begin
					// Underlying data returned unchanged, little-endian lanes
					next_state    = bbr_pkg::st_idle;
					next_up_ready = 1'b1;
					next_up_done  = 1'b1;
					next_up_rdata = dn_rdata_i;
					next_dn_write = 1'b0;
				end
			end
			default: begin
				next_state    = bbr_pkg::st_idle;
				next_up_ready = 1'b1;
			end
		endcase
	end

	// Sequencer and context registers
	always_ff @(posedge core_clk_i or negedge rst_b) begin
		if (!rst_b) begin
			state       <= bbr_pkg::st_idle;
			alias_write <= 1'b0;
			alias_wbit  <= 1'b0;
			alias_bit   <= 5'h00;
		end else if (ce_i) begin
			state       <= next_state;
			alias_write <= next_alias_write;
			alias_wbit  <= next_alias_wbit;
			alias_bit   <= next_alias_bit;
		end
	end

	// Upstream answer registers
	always_ff @(posedge core_clk_i or negedge rst_b) begin
		if (!rst_b) begin
			up_ready_o <= 1'b0;
			up_done_o  <= 1'b0;
			up_fault_o <= 1'b0;
			up_rdata_o <= bbr_pkg::WORD_ZERO;
		end else if (ce_i) begin
			up_ready_o <= next_up_ready;
			up_done_o  <= next_up_done;
			up_fault_o <= next_up_fault;
			up_rdata_o <= next_up_rdata;
		end
	end

	// Downstream request registers
	always_ff @(posedge core_clk_i or negedge rst_b) begin
		if (!rst_b) begin
			dn_req_o   <= 1'b0;
			dn_addr_o  <= bbr_pkg::WORD_ZERO;
			dn_write_o <= 1'b0;
			dn_size_o  <= bbr_pkg::SIZE_BYTE;
			dn_wdata_o <= bbr_pkg::WORD_ZERO;
		end else if (ce_i) begin
			dn_req_o   <= next_dn_req;
			dn_addr_o  <= next_dn_addr;
			dn_write_o <= next_dn_write;
			dn_size_o  <= next_dn_size;
			dn_wdata_o <= next_dn_wdata;
		end
	end
endmodule

// File: bbr_top_monitor.sv
`timescale 1ns/1ps
module bbr_monitor (
	// Clock, reset, enable
	input wire logic        core_clk_i,
	input wire logic        rst_b_i,
	input wire logic        ce_i,
	// Upstream side
	input wire logic        up_req_i,
	input wire logic [31:0] up_addr_i,
	input wire logic        up_write_i,
	input wire logic [1:0]  up_size_i,
	input wire logic [31:0] up_wdata_i,
	input wire logic        up_instr_i,
	input wire logic        up_ready_o,
	input wire logic        up_done_o,
	input wire logic        up_fault_o,
	input wire logic [31:0] up_rdata_o,
	// Downstream side
	input wire logic        dn_req_o,
	input wire logic [31:0] dn_addr_o,
	input wire logic        dn_write_o,
	input wire logic [1:0]  dn_size_o,
	input wire logic [31:0] dn_wdata_o,
	input wire logic        dn_done_i,
	input wire logic [31:0] dn_rdata_i
);
	// Request decode as seen at the core side
	wire        take = ce_i & up_ready_o & up_req_i;
	wire        flt  = up_instr_i & (up_addr_i[31:25] == 7'h21);
	wire        hit  = !up_instr_i & ((up_addr_i[31:21] == 11'h110) | (up_addr_i[31:25] == 7'h21));
	wire [31:0] ba   = (up_addr_i[30] ? bbr_pkg::PERI_BAND_BASE : bbr_pkg::SRAM_BAND_BASE) + {12'h000, up_addr_i[24:5]};
	wire [31:0] ea   = (up_size_i == bbr_pkg::SIZE_WORD) ? (ba & bbr_pkg::ALIGN_WORD) :
	                   (up_size_i == bbr_pkg::SIZE_HALF) ? (ba & bbr_pkg::ALIGN_HALF) : ba;
	logic        a_rd, a_wr, p_rd, w0;
	logic [4:0]  pos;
	logic [31:0] rd;
	// Remember the operation in flight and the last fabric read data
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			{a_rd, a_wr, p_rd, w0, pos, rd} <= '0;
		end else if (ce_i) begin
			if (take) begin
				a_rd <= hit & !up_write_i;
				a_wr <= hit & up_write_i;
				p_rd <= !hit & !flt & !up_write_i;
				w0   <= up_wdata_i[0];
				pos  <= {up_addr_i[6:5], up_addr_i[4:2]};
			end else if (up_done_o) begin
				{a_rd, a_wr, p_rd} <= '0;
			end
			if (dn_done_i) rd <= dn_rdata_i;
		end
	end
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	a_fetch_refused: assert property (take && flt |=> up_done_o && up_fault_o && !dn_req_o && up_rdata_o == 32'h0000_0000)
		else $error("peripheral alias fetch not refused");
	a_alias_addr: assert property (take && hit |=> dn_req_o && !dn_write_o && dn_addr_o == $past(ea))
		else $error("alias remap address wrong");
	a_size_kept: assert property (take && !flt |=> dn_size_o == $past(up_size_i))
		else $error("access size changed");
	a_pass_thru: assert property (take && !hit && !flt |=> dn_req_o && dn_addr_o == $past(up_addr_i) && dn_write_o == $past(up_write_i))
		else $error("direct access altered");
	a_rmw_bit: assert property (dn_req_o && dn_write_o && a_wr |-> dn_wdata_o == ((rd & ~(32'h0000_0001 << pos)) | ({31'h0, w0} << pos)))
		else $error("write back data wrong");
	a_alias_rd_val: assert property (up_done_o && a_rd |-> up_rdata_o == {31'h0, rd[pos]})
		else $error("alias read value wrong");
	a_pass_data: assert property (dn_done_i && p_rd |=> up_done_o && up_rdata_o == $past(dn_rdata_i))
		else $error("direct read data wrong");
	a_rmw_done: assert property (dn_done_i && a_wr && dn_write_o |=> up_done_o && up_ready_o && up_rdata_o == 32'h0000_0000)
		else $error("alias write did not finish");
	a_dn_pulse: assert property (dn_req_o |=> !dn_req_o)
		else $error("downstream request not a pulse");
endmodule
bind bbr_top bbr_monitor mon (
	.core_clk_i (core_clk_i),
	.rst_b_i    (rst_b_i),
	.ce_i       (ce_i),
	.up_req_i   (up_req_i),
	.up_addr_i  (up_addr_i),
	.up_write_i (up_write_i),
	.up_size_i  (up_size_i),
	.up_wdata_i (up_wdata_i),
	.up_instr_i (up_instr_i),
	.up_ready_o (up_ready_o),
	.up_done_o  (up_done_o),
	.up_fault_o (up_fault_o),
	.up_rdata_o (up_rdata_o),
	.dn_req_o   (dn_req_o),
	.dn_addr_o  (dn_addr_o),
	.dn_write_o (dn_write_o),
	.dn_size_o  (dn_size_o),
	.dn_wdata_o (dn_wdata_o),
	.dn_done_i  (dn_done_i),
	.dn_rdata_i (dn_rdata_i)
);

// File: bbr_mem_model.sv
`timescale 1ns/1ps
module bbr_mem_model (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// Request from the remapper
	input  wire logic        req_i,
	input  wire logic [31:0] addr_i,
	input  wire logic        write_i,
	input  wire logic [1:0]  size_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic [1:0]  lat_i,
	// Answer
	output logic             done_o,
	output logic [31:0]      rdata_o
);
	logic [31:0] mem [16];
	logic [1:0]  cnt;
	logic        busy;
	// Byte lanes chosen by size and low address bits
	wire [31:0] be = (size_i == 2'h2) ? 32'hFFFF_FFFF : (size_i == 2'h1) ? (32'h0000_FFFF << {addr_i[1], 4'h0}) :
	                 (32'h0000_00FF << {addr_i[1:0], 3'h0});
	// Answer after a chosen delay; idle read bus inverts every cycle, so stale data matches only on alternate cycles
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			{busy, done_o, cnt, rdata_o} <= '0;
		end else begin
			done_o  <= 1'b0;
			rdata_o <= ~rdata_o;
			if (req_i) begin
				busy <= 1'b1;
				cnt  <= lat_i;
			end else if (busy && cnt != 2'h0) begin
				cnt <= cnt - 2'h1;
			end else if (busy) begin
				busy    <= 1'b0;
				done_o  <= 1'b1;
				rdata_o <= mem[addr_i[5:2]];
				if (write_i) mem[addr_i[5:2]] <= (mem[addr_i[5:2]] & ~be) | (wdata_i & be);
			end
		end
	end
endmodule

// File: tb_bit_band_alias_remapper.sv
`timescale 1ns/1ps
module tb_bit_band_alias_remapper;
	logic clk = 0, rst_b = 0, req = 0, wr = 0, ins = 0, flt_seen, rdy, dn, ft, dq, dw, dd;
	logic [1:0]  sz = 0, lat = 0, ds;
	logic [31:0] ad = 0, wd = 0, got, rda, da, dwd, drd, a, d;
	logic [31:0] sh [16];
	logic [31:0] cor [4] = '{32'h2200_0000, 32'h2200_001C, 32'h221F_FFFC, 32'h43FF_FFFC};
	int fail_count = 0, comparisons = 0, seed = 51;
	always #25 clk = ~clk;
	bbr_top dut (.core_clk_i(clk), .rst_b_i(rst_b), .ce_i(1'b1), .up_req_i(req), .up_addr_i(ad), .up_write_i(wr),
		.up_size_i(sz), .up_wdata_i(wd), .up_instr_i(ins), .up_ready_o(rdy), .up_done_o(dn), .up_fault_o(ft),
		.up_rdata_o(rda), .dn_req_o(dq), .dn_addr_o(da), .dn_write_o(dw), .dn_size_o(ds), .dn_wdata_o(dwd),
		.dn_done_i(dd), .dn_rdata_i(drd));
	bbr_mem_model fab (.clk_i(clk), .rst_b_i(rst_b), .req_i(dq), .addr_i(da), .write_i(dw), .size_i(ds),
		.wdata_i(dwd), .lat_i(lat), .done_o(dd), .rdata_o(drd));
	task chk(string n, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	// Compare of a single status flag
	task chk_flag(string n, logic e, logic g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %b seen %b", n, e, g);
		end
	endtask
	// Model word that holds the bit an alias address targets (byte offset is aa[24:5])
	function automatic logic [3:0] band_word(logic [31:0] aa);
		return aa[10:7];
	endfunction
	// Bit in that word: byte lane of the offset, then the bit number
	function automatic logic [4:0] band_bit(logic [31:0] aa);
		return {aa[6:5], aa[4:2]};
	endfunction
	// A fetch from the peripheral alias window is refused
	function automatic logic fetch_refused(logic [31:0] aa, logic fi);
		return fi && (aa >= 32'h4200_0000) && (aa <= 32'h43FF_FFFF);
	endfunction
	// One upstream transfer, waiting a bounded time for its end
	task op(logic [31:0] oa, logic w, logic [1:0] s, logic [31:0] od, logic i);
		int n;
		@(posedge clk);
		req <= 1;
		ad  <= oa;
		wr  <= w;
		sz  <= s;
		wd  <= od;
		ins <= i;
		lat <= 2'($random(seed));
		@(posedge clk);
		req <= 0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (dn !== 1'b1 && n < 40);
		chk_flag("done", 1'b1, dn);
		got = rda;
		flt_seen = ft;
		chk_flag("fault_flag", fetch_refused(oa, i), ft);
	endtask
	task results;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#500_000;
		fail_count++;
		results;
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1;
		repeat (4) @(negedge clk);
		for (int k = 0; k < 16; k++) begin
			d = $random(seed);
			sh[k] = d;
			op(32'h2000_0000 + 32'(4 * k), 1'b1, 2'h2, d, 1'b0);
		end
		for (int k = 0; k < 16; k++) begin
			op(32'h4000_0000 + 32'(4 * k), 1'b0, 2'h2, 32'h0000_0000, 1'b0);
			chk("direct", sh[k], got);
		end
		// Byte writes land in the lane of their address
		repeat (8) begin
			a = 32'h2000_0000 + ($random(seed) & 63);
			d = $random(seed);
			op(a, 1'b1, 2'h0, d, 1'b0);
			sh[a[5:2]][8 * a[1:0] +: 8] = d[8 * a[1:0] +: 8];
			op(a & 32'hFFFF_FFFC, 1'b0, 2'h2, 32'h0000_0000, 1'b0);
			chk("lane", sh[a[5:2]], got);
		end
		// Random and corner alias writes and reads in every size
		for (int k = 0; k < 64; k++) begin
			a = (k < 4) ? cor[k] : (($random(seed) & 1) ? 32'h4200_0000 : 32'h2200_0000) | ($random(seed) & 32'h001F_FFFF);
			d = (k < 4) ? 32'hFFFF_FFFF : $random(seed);
			op(a, 1'b1, 2'(k % 3), d, 1'b0);
			sh[band_word(a)][band_bit(a)] = d[0];
			chk("alias_wr", 32'h0000_0000, got);
			op(32'h2000_0000 + {26'h000_0000, band_word(a), 2'h0}, 1'b0, 2'h2, 32'h0000_0000, 1'b0);
			chk("band", sh[band_word(a)], got);
			op(a ^ 32'h0000_0003, 1'b0, 2'((k + 1) % 3), 32'h0000_0000, 1'b0);
			chk("alias_rd", {31'h0, sh[band_word(a)][band_bit(a)]}, got);
		end
		op(32'h4200_0004, 1'b0, 2'h2, 32'h0000_0000, 1'b1);
		chk_flag("fault", 1'b1, flt_seen);
		chk("fetch_rd", 32'h0000_0000, got);
		op(32'h2200_0004, 1'b0, 2'h2, 32'h0000_0000, 1'b1);
		chk("fetch_sram", sh[1], got);
		results;
	end
endmodule
